// file: dual_timer_interrupt_unit.sv
// Purpose: Two prescaled down counters with the interrupt request, priority and vector logic.
// Assumes: Pins are asynchronous; the program memory answers one cycle after its address.
// Notes:   All state but the reset synchroniser lives in one packed struct registered by a single process.
`timescale 1ns/1ps

// Summary of operation
// - Two independent 8-bit counters, each with its own 6-bit prescaler.
// - Timer zero prescaler uses internal clock only; timer one may use external.
// - Prescalers divide by any ratio 1 to 64.
// - Counter decrements per prescaler tick from a load meaning 1 to 256.
// - End of count raises request line four or five.
// - Software starts, stops, continues, or restarts from the load value.
// - Single pass halts at zero; continuous mode reloads and keeps counting.
// - Counter reads never disturb counting; prescalers read as zero.
// - Timer one source is core clock divided by four or the input pin.
// - Input pin acts as clock, retriggerable or one-shot trigger, or gate.
// - Output pin shows timer zero, timer one, or the internal clock.
// - Cascade routes timer zero output into timer one.
// - Priority select sets the order among pending requests.
// - Grant disables interrupts, saves context, branches through its vector.
// - A vector is two program bytes forming a 16-bit address.
// - Masked requests stay visible in the request register for polling.
// - First comparator maps to line two, second comparator to line zero.
// - Request register bits 7 and 6 select edges of the two selectable pins.
// - Vectors sit in bytes 0 to 11; line n uses 2n and 2n+1.
// - The two fixed pins request on falling edges only.
// - Timer one input is the timer input pin, output the timer output pin.
module dual_timer_interrupt_unit
  import dual_timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire reg_req_type reg_req_i,
  output logic [7:0]       reg_rdata_o,
  input  wire pin_in_type  pins_i,
  output logic             timer_output_pin_o,
  output logic [7:0]       pmem_addr_o,
  output logic             pmem_rd_o,
  input  wire logic [7:0]  pmem_data_i,
  output logic             save_ctx_o,
  output logic [15:0]      isr_addr_o,
  output logic             isr_valid_o
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    timer_type [1:0] tm;
    logic            ext_src;
    logic            cascade;
    tin_mode_type    tin_mode;
    tout_sel_type    tout_sel;
    logic [2:0]      prio;
    logic [5:0]      flags;
    logic [1:0]      edge_sel;
    logic [5:0]      mask;
    logic            analog;
    logic            global_en;
    logic [1:0]      div;
    logic [5:0]      s1;
    logic [5:0]      s2;
    logic [5:0]      s3;
    logic [5:0]      lvl;
    vec_state_type   vst;
    logic [2:0]      line;
    logic [7:0]      vec_hi;
    logic [15:0]     isr_addr;
    logic            isr_valid;
    logic            save_ctx;
    logic [7:0]      pmem_addr;
    logic            pmem_rd;
    logic [7:0]      rdata;
    logic            tout;
  } state_type;

  state_type  st_q;
  state_type  st_d;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       int_tick;
  logic [1:0] src;
  logic [1:0] tick;
  logic [1:0] endc;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] set_v;
  logic [5:0] pend;
  logic       grant;
  logic [2:0] grant_line;
  logic       wr_mode;

  // Chooses the first pending line at or after the start line, wrapping round.
  function automatic logic [2:0] pick_line(input logic [5:0] p, input logic [2:0] start);
    logic [2:0] res;
    int         j;
    res = 3'h0;
    for (int k = NUM_LINES - 1; k >= 0; k--) begin
      j = ((start > 3'h5 ? 0 : int'(start)) + k) % NUM_LINES;
      if (p[j]) begin
        res = 3'(j);
      end
    end
    return res;
  endfunction : pick_line

  // Edge choice of a selectable pin: both edges, else rising when sel is set.
  function automatic logic edge_hit(input logic r, input logic f, input logic sel, input logic both);
    return both ? (r | f) : (sel ? r : f);
  endfunction : edge_hit

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // The release is synchronised so every flop leaves reset on the same edge.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Combinational decode of events
  // ----------------------------------------------------------------
  // Pin edges use the filtered level, so a glitch shorter than two cycles is lost.
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      rise[i] = 1'b0;
      fall[i] = 1'b0;
      if (st_q.s2[i] == st_q.s3[i]) begin
        rise[i] = st_q.s3[i] & ~st_q.lvl[i];
        fall[i] = ~st_q.s3[i] & st_q.lvl[i];
      end
    end
  end

  // Clock sources and prescaler ticks of both timers.
  always_comb begin
    int_tick = (st_q.div == INT_DIV_LAST);
    src[0]   = int_tick;
    // Timer zero settles first, since its end of count may clock timer one.
    tick[0]  = st_q.tm[0].run & src[0] & (st_q.tm[0].pre == 6'h00);
    endc[0]  = tick[0] & (st_q.tm[0].cnt == END_COUNT);
    if (st_q.cascade) begin
      src[1] = endc[0];
    end else if (!st_q.ext_src) begin
      src[1] = int_tick;
    end else begin
      unique case (st_q.tin_mode)
        TIN_EXT_CLOCK: src[1] = fall[PIN_TIN];
        TIN_GATE:      src[1] = int_tick & st_q.lvl[PIN_TIN];
        default:       src[1] = int_tick;
      endcase
    end
    tick[1] = st_q.tm[1].run & src[1] & (st_q.tm[1].pre == 6'h00);
    endc[1] = tick[1] & (st_q.tm[1].cnt == END_COUNT);
  end

  // Request sources, priority and grant.
  always_comb begin
    set_v[0] = edge_hit(rise[st_q.analog ? PIN_COMP2 : PIN_SEL2], fall[st_q.analog ? PIN_COMP2 : PIN_SEL2],
                        st_q.edge_sel[0], &st_q.edge_sel);
    set_v[1] = fall[PIN_FALL_B];
    set_v[2] = edge_hit(rise[st_q.analog ? PIN_COMP1 : PIN_TIN], fall[st_q.analog ? PIN_COMP1 : PIN_TIN],
                        st_q.edge_sel[1], &st_q.edge_sel);
    set_v[3] = fall[PIN_FALL_A];
    set_v[4] = endc[0];
    set_v[5] = endc[1];
    pend       = st_q.flags & st_q.mask;
    grant      = st_q.global_en & (st_q.vst == VEC_IDLE) & (|pend);
    grant_line = pick_line(pend, st_q.prio);
    wr_mode    = reg_req_i.we & (reg_req_i.addr == TIMER_MODE_ADDR);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.save_ctx  = 1'b0;
    st_d.isr_valid = 1'b0;
    st_d.pmem_rd   = 1'b0;
    st_d.rdata     = 8'h00;
    st_d.div       = st_q.div + 2'h1;

    // Three-stage pin capture; the first stage feeds only the second.
    st_d.s1 = pins_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end

    // Prescalers and counters; the prescaler only advances while running.
    for (int i = 0; i < 2; i++) begin
      if (st_q.tm[i].run && src[i]) begin
        st_d.tm[i].pre = (st_q.tm[i].pre == 6'h00) ? st_q.tm[i].scale - 6'h01
                                                   : st_q.tm[i].pre - 6'h01;
      end
      if (tick[i]) begin
        if (endc[i]) begin
          st_d.tm[i].out = ~st_q.tm[i].out;
          if (st_q.tm[i].cont) begin
            st_d.tm[i].cnt = st_q.tm[i].load;
          end else begin
            st_d.tm[i].cnt = 8'h00;
            st_d.tm[i].run = 1'b0;
          end
        end else begin
          st_d.tm[i].cnt = st_q.tm[i].cnt - 8'h01;
        end
      end
    end

    // Trigger modes start timer one on a falling pin edge.
    if (st_q.ext_src && !st_q.cascade && fall[PIN_TIN] &&
        ((st_q.tin_mode == TIN_TRIG_RETRIG) || (st_q.tin_mode == TIN_TRIG_ONCE && !st_q.tm[1].run))) begin
      st_d.tm[1].cnt = st_q.tm[1].load;
      st_d.tm[1].pre = st_q.tm[1].scale - 6'h01;
      st_d.tm[1].run = 1'b1;
    end

    // Register writes act after the counters, so software has the last word.
    if (reg_req_i.we) begin
      unique case (reg_req_i.addr)
        TIMER_MODE_ADDR: begin
          st_d.tm[0].run = reg_req_i.wdata[TM_RUN0];
          st_d.tm[1].run = reg_req_i.wdata[TM_RUN1];
          st_d.tin_mode  = tin_mode_type'(reg_req_i.wdata[TM_TIN_LSB +: 2]);
          st_d.tout_sel  = tout_sel_type'(reg_req_i.wdata[TM_TOUT_LSB +: 2]);
          if (reg_req_i.wdata[TM_LOAD0]) begin
            st_d.tm[0].cnt = st_q.tm[0].load;
            st_d.tm[0].pre = st_q.tm[0].scale - 6'h01;
          end
          if (reg_req_i.wdata[TM_LOAD1]) begin
            st_d.tm[1].cnt = st_q.tm[1].load;
            st_d.tm[1].pre = st_q.tm[1].scale - 6'h01;
          end
        end
        TIMER_ZERO_COUNT_ADDR: st_d.tm[0].load = reg_req_i.wdata;
        TIMER_ONE_COUNT_ADDR:  st_d.tm[1].load = reg_req_i.wdata;
        TIMER_ZERO_PRESCALE_ADDR: begin
          st_d.tm[0].scale = reg_req_i.wdata[PS_SCALE_LSB +: 6];
          st_d.tm[0].cont  = reg_req_i.wdata[PS_CONT];
          st_d.cascade     = reg_req_i.wdata[PS_SRC];
        end
        TIMER_ONE_PRESCALE_ADDR: begin
          st_d.tm[1].scale = reg_req_i.wdata[PS_SCALE_LSB +: 6];
          st_d.tm[1].cont  = reg_req_i.wdata[PS_CONT];
          st_d.ext_src     = reg_req_i.wdata[PS_SRC];
        end
        PRIORITY_ADDR: st_d.prio = reg_req_i.wdata[2:0];
        REQUEST_ADDR: begin
          st_d.flags    = reg_req_i.wdata[NUM_LINES-1:0];
          st_d.edge_sel = reg_req_i.wdata[RQ_EDGE_LSB +: 2];
        end
        MASK_ADDR: begin
          st_d.mask      = reg_req_i.wdata[NUM_LINES-1:0];
          st_d.analog    = reg_req_i.wdata[MK_ANALOG];
          st_d.global_en = reg_req_i.wdata[MK_GLOBAL];
        end
        default: ;
      endcase
    end

    // Reads only copy state out; a prescaler or priority read returns zero.
    if (reg_req_i.re) begin
      unique case (reg_req_i.addr)
        TIMER_MODE_ADDR:       st_d.rdata = {st_q.tout_sel, st_q.tin_mode, st_q.tm[1].run, 1'b0,
                                             st_q.tm[0].run, 1'b0};
        TIMER_ZERO_COUNT_ADDR: st_d.rdata = st_q.tm[0].cnt;
        TIMER_ONE_COUNT_ADDR:  st_d.rdata = st_q.tm[1].cnt;
        REQUEST_ADDR:          st_d.rdata = {st_q.edge_sel, st_q.flags};
        MASK_ADDR:             st_d.rdata = {st_q.global_en, st_q.analog, st_q.mask};
        default:               st_d.rdata = 8'h00;
      endcase
    end

    // Vector fetch sequence: high byte at 2n, low byte at 2n+1.
    unique case (st_q.vst)
      VEC_IDLE: begin
        if (grant) begin
          st_d.global_en       = 1'b0;
          st_d.save_ctx        = 1'b1;
          st_d.flags[grant_line] = 1'b0;
          st_d.line            = grant_line;
          st_d.pmem_addr       = {4'h0, grant_line, 1'b0};
          st_d.pmem_rd         = 1'b1;
          st_d.vst             = VEC_ADDR_HI;
        end
      end
      VEC_ADDR_HI: begin
        st_d.pmem_addr = {4'h0, st_q.line, 1'b1};
        st_d.pmem_rd   = 1'b1;
        st_d.vst       = VEC_ADDR_LO;
      end
      VEC_ADDR_LO: begin
        st_d.vec_hi = pmem_data_i;
        st_d.vst    = VEC_TAKE_LO;
      end
      VEC_TAKE_LO: begin
        st_d.isr_addr  = {st_q.vec_hi, pmem_data_i};
        st_d.isr_valid = 1'b1;
        st_d.vst       = VEC_IDLE;
      end
    endcase

    // New events win over any clear in the same cycle.
    st_d.flags = st_d.flags | set_v;

    // Output pin selection.
    unique case (st_q.tout_sel)
      TOUT_OFF:        st_d.tout = 1'b0;
      TOUT_TIMER_ZERO: st_d.tout = st_q.tm[0].out;
      TOUT_TIMER_ONE:  st_d.tout = st_q.tm[1].out;
      TOUT_INT_CLOCK:  st_d.tout = st_q.div[1];
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves both counters stopped and every request clear.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.s1   <= PIN_IDLE;
      st_q.s2   <= PIN_IDLE;
      st_q.s3   <= PIN_IDLE;
      st_q.lvl  <= PIN_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o        = st_q.rdata;
  assign timer_output_pin_o = st_q.tout;
  assign pmem_addr_o        = st_q.pmem_addr;
  assign pmem_rd_o          = st_q.pmem_rd;
  assign save_ctx_o         = st_q.save_ctx;
  assign isr_addr_o         = st_q.isr_addr;
  assign isr_valid_o        = st_q.isr_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_count_read_copy: assert property (reg_req_i.re && reg_req_i.addr == TIMER_ZERO_COUNT_ADDR
    |=> reg_rdata_o == $past(st_q.tm[0].cnt)) else $error("counter read returned wrong value");
  a_prescale_read_zero: assert property (reg_req_i.re && reg_req_i.addr == TIMER_ONE_PRESCALE_ADDR
    |=> reg_rdata_o == 8'h00) else $error("prescaler read was not zero");
  a_end_sets_request: assert property (endc[1] |=> st_q.flags[5]) else $error("timer one end lost");
  a_reload_same_tick: assert property (endc[0] && st_q.tm[0].cont && !wr_mode
    |=> st_q.tm[0].cnt == $past(st_q.tm[0].load) && st_q.tm[0].run) else $error("reload missed");
  a_single_pass_halt: assert property (endc[0] && !st_q.tm[0].cont && !wr_mode
    |=> !st_q.tm[0].run && st_q.tm[0].cnt == 8'h00) else $error("single pass did not halt");
  a_internal_div_four: assert property (int_tick |=> !int_tick [*3] ##1 int_tick)
    else $error("internal clock is not divided by four");
  a_grant_disables: assert property (grant |=> !st_q.global_en && save_ctx_o)
    else $error("grant did not disable interrupts");
  a_vector_fetch: assert property (grant |=> pmem_addr_o == {4'h0, $past(grant_line), 1'b0}
    ##1 pmem_addr_o == {4'h0, st_q.line, 1'b1} ##2 isr_valid_o) else $error("vector fetch out of order");
  a_falling_pin_req: assert property (fall[PIN_FALL_A] |=> st_q.flags[3])
    else $error("falling edge request lost");

  c_timer_one_end: cover property (endc[1]);
  c_vector_done: cover property (isr_valid_o);
  c_cascade_run: cover property (st_q.cascade && endc[0] && st_q.tm[1].run);
  c_trigger_start: cover property (st_q.ext_src && fall[PIN_TIN] && st_q.tin_mode == TIN_TRIG_RETRIG);

endmodule : dual_timer_interrupt_unit

// file: dual_timer_interrupt_unit_test.sv
// Purpose: Self-checking bench for the dual timer and interrupt unit.
// Assumes: Program memory answers one cycle after its address.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/1ps
module dual_timer_interrupt_unit_test;
  import dual_timer_pkg::*;
  logic        clk;
  logic        rstn;
  reg_req_type reg_req;
  logic [7:0]  rdata;
  logic [4:0]  hi_pins;
  logic        tin;
  pin_in_type  pins;
  logic        tout;
  logic [7:0]  pmem_addr;
  logic        pmem_rd;
  logic [7:0]  pmem_data = 8'h00;
  logic        save_ctx;
  logic [15:0] isr_addr;
  logic        isr_valid;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  rd;

  // ----------------------------------------
  // Clock, pins and program memory
  // ----------------------------------------
  // Core clock at 250 MHz.
  initial clk = 1'b0;
  always #2 clk = ~clk;
  assign pins = {hi_pins, tin};
  // Each vector byte is derived from its address, so every byte differs.
  always @(posedge clk) pmem_data <= pmem_addr ^ 8'hA5;

  dual_timer_interrupt_unit dual_timer_interrupt_unit_inst (
    .clk_i(clk), .rstn_i(rstn), .reg_req_i(reg_req), .reg_rdata_o(rdata),
    .pins_i(pins), .timer_output_pin_o(tout), .pmem_addr_o(pmem_addr),
    .pmem_rd_o(pmem_rd), .pmem_data_i(pmem_data), .save_ctx_o(save_ctx),
    .isr_addr_o(isr_addr), .isr_valid_o(isr_valid));
  tin_source_model tin_source_model_inst (.clk_i(clk), .pin_o(tin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    reg_req.we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    reg_req.re <= 1'b0;
    #1 rd = rdata;
  endtask : rdreg

  // Cycles between two changes of the timer output pin.
  task automatic gap(output int n);
    logic last;
    n = 0;
    last = tout;
    for (int i = 0; i < 40 && tout === last; i++) begin
      @(posedge clk);
      #1;
    end
    last = tout;
    while (n < 40 && tout === last) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : gap

  task automatic pin_step(input int idx, input logic v, input logic [7:0] exp);
    @(posedge clk);
    hi_pins[idx] <= v;
    repeat (10) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd, exp, "pin event");
  endtask : pin_step

  task automatic grant(input logic [7:0] base);
    wr(MASK_ADDR, 8'hB0);
    for (int i = 0; i < 8 && save_ctx !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(save_ctx, 1'b1, "context save");
    chk(pmem_rd, 1'b1, "vector fetch");
    chk(pmem_addr, base, "high byte address");
    @(posedge clk);
    #1;
    chk(pmem_addr, base + 8'h01, "low byte address");
    for (int i = 0; i < 6 && isr_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(isr_valid, 1'b1, "service address valid");
    chk(isr_addr[15:8], base ^ 8'hA5, "service address high");
    chk(isr_addr[7:0], (base + 8'h01) ^ 8'hA5, "service address low");
  endtask : grant

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdreg(REQUEST_ADDR);
    chk(rd, 8'h00, "flags after reset");
    rdreg(TIMER_MODE_ADDR);
    chk(rd, 8'h00, "mode after reset");
    rdreg(TIMER_ZERO_PRESCALE_ADDR);
    chk(rd, 8'h00, "prescaler read");
    rdreg(8'h10);
    chk(rd, 8'h00, "unmapped read");
  endtask : t_reset

  // Ratio 2, load 3: the request needs 24 cycles.
  task automatic t_single;
    wr(TIMER_ZERO_PRESCALE_ADDR, 8'h08);
    wr(TIMER_ZERO_COUNT_ADDR, 8'h03);
    wr(TIMER_MODE_ADDR, 8'h03);
    repeat (10) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd, 8'h00, "early end of count");
    repeat (26) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd, 8'h10, "timer zero request");
    rdreg(TIMER_ZERO_COUNT_ADDR);
    chk(rd, 8'h00, "single pass halts");
    rdreg(TIMER_MODE_ADDR);
    chk(rd, 8'h00, "run cleared");
  endtask : t_single

  // Continuous, ratio 1, load 2: the output toggles every 8 cycles.
  task automatic t_cont;
    int n;
    logic [7:0] held;
    wr(TIMER_ZERO_PRESCALE_ADDR, 8'h05);
    wr(TIMER_ZERO_COUNT_ADDR, 8'h02);
    wr(TIMER_MODE_ADDR, 8'h43);
    // The first change may be the output select taking effect, not a toggle.
    gap(n);
    gap(n);
    chk(8'(n), 8'd8, "continuous period");
    gap(n);
    chk(8'(n), 8'd8, "output pin period");
    wr(TIMER_MODE_ADDR, 8'h40);
    rdreg(TIMER_ZERO_COUNT_ADDR);
    held = rd;
    repeat (20) @(posedge clk);
    rdreg(TIMER_ZERO_COUNT_ADDR);
    chk(rd, held, "stopped count");
    wr(TIMER_MODE_ADDR, 8'h42);
    gap(n);
    chk(8'(n), 8'd8, "continued period");
    wr(TIMER_MODE_ADDR, 8'h00);
  endtask : t_cont

  // Timer one counts falling edges on the input pin; load 3.
  task automatic t_ext;
    wr(REQUEST_ADDR, 8'h00);
    wr(TIMER_ONE_PRESCALE_ADDR, 8'h06);
    wr(TIMER_ONE_COUNT_ADDR, 8'h03);
    wr(TIMER_MODE_ADDR, 8'h0C);
    tin_source_model_inst.pulse(2, 6);
    repeat (12) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd & 8'h20, 8'h00, "two edges");
    tin_source_model_inst.pulse(1, 6);
    repeat (12) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd & 8'h20, 8'h20, "third edge ends count");
    wr(TIMER_MODE_ADDR, 8'h00);
  endtask : t_ext

  // Cascade: timer zero ends every 8 cycles and clocks timer one, load 2.
  task automatic t_cascade;
    wr(TIMER_ZERO_PRESCALE_ADDR, 8'h07);
    wr(TIMER_ZERO_COUNT_ADDR, 8'h02);
    wr(TIMER_ONE_PRESCALE_ADDR, 8'h04);
    wr(TIMER_ONE_COUNT_ADDR, 8'h02);
    wr(REQUEST_ADDR, 8'h00);
    wr(TIMER_MODE_ADDR, 8'h0F);
    repeat (7) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd & 8'h20, 8'h00, "cascade early end");
    repeat (8) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd & 8'h20, 8'h20, "cascade end of count");
    rdreg(TIMER_ONE_COUNT_ADDR);
    chk(rd, 8'h00, "cascade single pass");
    wr(TIMER_MODE_ADDR, 8'h00);
    wr(TIMER_ZERO_PRESCALE_ADDR, 8'h00);
  endtask : t_cascade

  task automatic t_edges;
    wr(REQUEST_ADDR, 8'h40);
    pin_step(0, 1'b0, 8'h40);
    pin_step(0, 1'b1, 8'h41);
    pin_step(1, 1'b0, 8'h49);
    pin_step(1, 1'b1, 8'h49);
    wr(MASK_ADDR, 8'h40);
    wr(REQUEST_ADDR, 8'h00);
    pin_step(3, 1'b0, 8'h04);
    pin_step(4, 1'b0, 8'h05);
    pin_step(3, 1'b1, 8'h05);
    pin_step(4, 1'b1, 8'h05);
    wr(MASK_ADDR, 8'h00);
  endtask : t_edges

  task automatic t_vector;
    wr(REQUEST_ADDR, 8'h30);
    wr(MASK_ADDR, 8'h30);
    repeat (6) @(posedge clk);
    rdreg(REQUEST_ADDR);
    chk(rd, 8'h30, "polled flags");
    wr(PRIORITY_ADDR, 8'h05);
    grant(8'h0A);
    rdreg(REQUEST_ADDR);
    chk(rd, 8'h10, "served flag cleared");
    grant(8'h08);
  endtask : t_vector

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // A hung handshake ends the run as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    rstn = 1'b0;
    reg_req = '0;
    hi_pins = 5'h1F;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_single();
    t_cont();
    t_ext();
    t_cascade();
    t_edges();
    t_vector();
    test_done();
  end
endmodule : dual_timer_interrupt_unit_test

// file: dual_timer_pkg.sv
// Purpose: Shared constants and types of the dual timer and interrupt unit.
// Assumes: Eight-bit register port; 250 MHz core clock.
// Notes:   Offsets are byte addresses on the register port.
package dual_timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_MODE_ADDR          = 8'hF1;
  localparam logic [7:0] TIMER_ONE_COUNT_ADDR     = 8'hF2;
  localparam logic [7:0] TIMER_ONE_PRESCALE_ADDR  = 8'hF3;
  localparam logic [7:0] TIMER_ZERO_COUNT_ADDR    = 8'hF4;
  localparam logic [7:0] TIMER_ZERO_PRESCALE_ADDR = 8'hF5;
  localparam logic [7:0] PRIORITY_ADDR            = 8'hF9;
  localparam logic [7:0] REQUEST_ADDR             = 8'hFA;
  localparam logic [7:0] MASK_ADDR                = 8'hFB;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TM_LOAD0      = 0;
  localparam int TM_RUN0       = 1;
  localparam int TM_LOAD1      = 2;
  localparam int TM_RUN1       = 3;
  localparam int TM_TIN_LSB    = 4;
  localparam int TM_TOUT_LSB   = 6;
  localparam int PS_CONT       = 0;
  localparam int PS_SRC        = 1;
  localparam int PS_SCALE_LSB  = 2;
  localparam int RQ_EDGE_LSB   = 6;
  localparam int MK_ANALOG     = 6;
  localparam int MK_GLOBAL     = 7;
  localparam int NUM_LINES     = 6;
  localparam logic [1:0] INT_DIV_LAST = 2'h3;
  localparam logic [5:0] PIN_IDLE     = 6'h3F;
  localparam logic [7:0] END_COUNT    = 8'h01;

  // Index of each synchronised pin.
  localparam int PIN_TIN     = 0;
  localparam int PIN_SEL2    = 1;
  localparam int PIN_FALL_A  = 2;
  localparam int PIN_FALL_B  = 3;
  localparam int PIN_COMP1   = 4;
  localparam int PIN_COMP2   = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TIN_EXT_CLOCK, TIN_GATE, TIN_TRIG_ONCE, TIN_TRIG_RETRIG} tin_mode_type;
  typedef enum logic [1:0] {TOUT_OFF, TOUT_TIMER_ZERO, TOUT_TIMER_ONE, TOUT_INT_CLOCK} tout_sel_type;
  typedef enum logic [1:0] {VEC_IDLE, VEC_ADDR_HI, VEC_ADDR_LO, VEC_TAKE_LO} vec_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_type;

  typedef struct packed {
    logic comp_second;
    logic comp_first;
    logic falling_edge_pin_b;
    logic falling_edge_pin_a;
    logic second_edge_select_pin;
    logic timer_input_pin;
  } pin_in_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] load;
    logic [5:0] pre;
    logic [5:0] scale;
    logic       run;
    logic       cont;
    logic       out;
  } timer_type;

endpackage : dual_timer_pkg

// file: tin_source_model.sv
// Purpose: External signal source on the timer input pin.
// Assumes: The pin idles high, as a pulled-up line would.
// Notes:   Half period is in core clocks, so slow and quick sources both fit.
`timescale 1ns/1ps
module tin_source_model (
  input  wire logic clk_i,
  output logic      pin_o
);
  // ----------------------------------------
  // Pulse generator
  // ----------------------------------------
  // Idle high, so that only the pulses give falling edges.
  initial pin_o = 1'b1;

  // A pulse is one falling and one rising edge; half must outlast the pin filter.
  task automatic pulse(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (half) @(posedge clk_i);
      pin_o <= 1'b1;
    end
  endtask : pulse
endmodule : tin_source_model
